/* verilog/hba_pkg.sv */
// shared constants and types of the host bus arbitration block
package hba_pkg;
   // host bus modes as strapped on the mode pins
   localparam logic [1:0] MODE_ONE = 2'h0;
   localparam logic [1:0] MODE_TWO = 2'h1;
   localparam logic [1:0] MODE_THREE = 2'h2;
   localparam logic [1:0] MODE_FOUR = 2'h3;
   // script memory window
   localparam int SCRIPT_BYTES = 4096;
   localparam int RAM_AW = 10;
   localparam int HOST_AW = 12;
   localparam int DATA_W = 32;
   // enable bits in the chip test control byte
   localparam int RAM_EN_BIT_A = 1;
   localparam int RAM_EN_BIT_B = 2;
   // worst case clocks to leave the bus on a late back-off
   localparam int RELEASE_CLKS = 2;
   // synchronised pin bundle: mode, seven strobes, address, data
   localparam int PIN_W = 2 + 7 + HOST_AW + DATA_W;
   // all strobes idle (inactive) after reset so no false edge follows it
   localparam logic [PIN_W-1:0] PIN_RST = {2'h0, 7'h00, {(HOST_AW + DATA_W){1'b0}}};
   // arbitration states, one-hot
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_REQ = 6'h02,
      ST_OWN = 6'h04,
      ST_CYCLE = 6'h08,
      ST_RELEASE = 6'h10,
      ST_BACKOFF = 6'h20
   } hba_state_t;
endpackage

/* verilog/hba_ram_if.sv */
// link between the arbiter and its script memory
`timescale 1ns/100ps
interface hba_ram_if;
   import hba_pkg::*;
   logic [RAM_AW-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic we;
   logic rd;
   logic [DATA_W-1:0] rdata;
   logic rvalid;
   modport ctl (output addr, wdata, we, rd, input rdata, rvalid);
   modport mem (input addr, wdata, we, rd, output rdata, rvalid);
endinterface

/* verilog/hba_script_ram.sv */
// script memory with registered read data
`timescale 1ns/100ps
module hba_script_ram #(
   parameter int DEPTH = hba_pkg::SCRIPT_BYTES / 4
) (
   input wire logic i_clk, // host bus clock
   hba_ram_if.mem ram      // access port
);
   import hba_pkg::*;

   logic [DATA_W-1:0] mem_q [DEPTH];

   // refuse a depth the address cannot reach
   if (DEPTH != (1 << RAM_AW))
   begin : g_depth_check
      $error("hba_script_ram: DEPTH must match RAM_AW");
   end

   // write port
   always_ff @(posedge i_clk)
   begin
      if (ram.we) mem_q[ram.addr] <= ram.wdata;
   end

   // registered read with a valid flag
   always_ff @(posedge i_clk)
   begin
      ram.rdata <= mem_q[ram.addr];
      ram.rvalid <= ram.rd;
   end
endmodule // hba_script_ram

/* verilog/hba_host_arbiter.sv */
// host bus mastership, slave select, script memory select and interrupt pins
`timescale 1ns/100ps
module hba_host_arbiter #(
   parameter int RAM_DEPTH = hba_pkg::SCRIPT_BYTES / 4
) (
   input wire logic i_clk,                              // host bus clock
   input wire logic i_rst,                              // synchronous reset, high
   input wire logic [1:0] i_bus_mode,                   // bus mode pins
   input wire logic i_host_grant_in_n,                  // grant, or prior master released
   input wire logic i_forced_release_in_n,              // back-off pin
   input wire logic i_mastership_taken_n,               // grant-ack wire level
   output logic o_mastership_taken_n,                   // grant-ack drive value
   output logic o_mastership_taken_oe,                  // grant-ack enable
   input wire logic i_mastership_wired_busy_n,          // bus busy wire level
   output logic o_mastership_wired_busy_n,              // bus busy drive value
   output logic o_mastership_wired_busy_oe,             // bus busy enable
   output logic o_host_bus_request_n,                   // request or hold pin
   input wire logic i_xfer_req,                         // engine wants master cycles
   input wire logic i_cycle_done,                       // current master cycle ends
   output logic o_start_cycle,                          // start cycle pulse
   output logic o_resume_cycle,                         // start repeats interrupted cycle
   output logic o_bus_owner,                            // block owns host bus
   input wire logic i_chip_select_n,                    // slave select pin
   output logic o_cache_ack_out_n,                      // cache ack drive value
   output logic o_cache_ack_oe,                         // cache ack enable
   output logic o_burst_inhibit_out_n,                  // burst inhibit drive value
   output logic o_burst_inhibit_oe,                     // burst inhibit enable
   output logic o_slave_selected,                       // slave access seen
   input wire logic i_script_memory_select_n,           // script memory select pin
   input wire logic [7:0] i_chip_test_ctrl_five,        // control byte
   input wire logic [hba_pkg::HOST_AW-1:0] i_host_addr, // host address low bits
   input wire logic [hba_pkg::DATA_W-1:0] i_host_wdata, // host write data
   input wire logic i_host_write,                       // host access is a write
   output logic [hba_pkg::DATA_W-1:0] o_ram_rdata,      // script memory read data
   output logic o_ram_rvalid,                           // read data valid pulse
   input wire logic i_service_req,                      // block needs host service
   output logic o_irq_n                                 // interrupt pin
);
   import hba_pkg::*;

   hba_state_t state;
   hba_state_t next_state;
   logic [PIN_W-1:0] pin_s1;
   logic [PIN_W-1:0] pin_s2;
   logic [1:0] mode;
   logic grant;
   logic forced_release_in_n;
   logic taken_busy;
   logic wired_busy;
   logic cs;
   logic rsel;
   logic wr;
   logic [HOST_AW-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic rsel_d;
   logic ram_hit;
   logic bus_free;
   logic owning;
   logic [1:0] rel_cnt;
   logic pending_retry;
   hba_ram_if ram ();

   // mode one uses the grant-ack line, the others the busy line
   function automatic logic is_mode_one(input logic [1:0] m);
      return m == MODE_ONE;
   endfunction

   if (RAM_DEPTH * 4 != SCRIPT_BYTES)
   begin : g_depth_check
      $error("hba_host_arbiter: RAM_DEPTH must span the window");
   end

   // two flip-flops on every pin input before use
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         pin_s1 <= PIN_RST;
         pin_s2 <= PIN_RST;
      end
      else
      begin
         pin_s1 <= {i_bus_mode, ~i_host_grant_in_n, ~i_forced_release_in_n,
                    ~i_mastership_taken_n, ~i_mastership_wired_busy_n, ~i_chip_select_n,
                    ~i_script_memory_select_n, i_host_write, i_host_addr, i_host_wdata};
         pin_s2 <= pin_s1;
      end
   end

   // unpack synchronised pins, all as active-high levels
   assign {mode, grant, forced_release_in_n, taken_busy, wired_busy, cs, rsel, wr, addr, wdata} = pin_s2;

   // bus free: granted and no other master holding the ownership wire
   assign bus_free = grant && !(is_mode_one(mode) ? taken_busy : wired_busy);

   // arbitration and back-off sequencing
   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
         begin
            if (i_xfer_req) next_state = ST_REQ;
         end
         ST_REQ:
         begin
            // arbitration completes even with back-off pending
            if (bus_free) next_state = ST_OWN;
         end
         ST_OWN:
         begin
            if (!i_xfer_req) next_state = ST_IDLE;
            else if (forced_release_in_n) next_state = ST_RELEASE;
            else next_state = ST_CYCLE;
         end
         ST_CYCLE:
         begin
            if (i_cycle_done)
            begin
               if (forced_release_in_n) next_state = ST_BACKOFF;
               else if (i_xfer_req) next_state = ST_OWN;
               else next_state = ST_IDLE;
            end
         end
         ST_RELEASE:
         begin
            if (rel_cnt == 2'(RELEASE_CLKS - 1)) next_state = ST_BACKOFF;
         end
         ST_BACKOFF:
         begin
            if (!forced_release_in_n) next_state = i_xfer_req ? ST_REQ : ST_IDLE;
         end
         default:
         begin
            next_state = ST_IDLE;
         end
      endcase
   end

   assign owning = (next_state == ST_OWN) || (next_state == ST_CYCLE) ||
                   (next_state == ST_RELEASE);

   // state register, cleared by reset, clocked by the bus clock only
   always_ff @(posedge i_clk)
   begin
      if (i_rst) state <= ST_IDLE;
      else state <= next_state;
   end

   // release cycle length counter
   always_ff @(posedge i_clk)
   begin
      if (i_rst) rel_cnt <= 2'h0;
      else if (state == ST_RELEASE) rel_cnt <= rel_cnt + 2'h1;
      else rel_cnt <= 2'h0;
   end

   // request held only while arbitrating, dropped once owner
   always_ff @(posedge i_clk)
   begin
      if (i_rst) o_host_bus_request_n <= 1'b1;
      else o_host_bus_request_n <= !(next_state == ST_REQ);
   end

   // ownership indication on the wire of the current mode
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_bus_owner <= 1'b0;
         o_mastership_taken_oe <= 1'b0;
         o_mastership_wired_busy_oe <= 1'b0;
      end
      else
      begin
         o_bus_owner <= owning;
         o_mastership_taken_oe <= owning && is_mode_one(mode);
         o_mastership_wired_busy_oe <= owning && !is_mode_one(mode);
      end
   end

   // owners pull the lines low; otherwise they are only watched
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_mastership_taken_n <= 1'b0;
         o_mastership_wired_busy_n <= 1'b0;
      end
      else
      begin
         o_mastership_taken_n <= 1'b0;
         o_mastership_wired_busy_n <= 1'b0;
      end
   end

   // start cycles, flagged when they repeat an interrupted one
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_start_cycle <= 1'b0;
         o_resume_cycle <= 1'b0;
         pending_retry <= 1'b0;
      end
      else
      begin
         o_start_cycle <= (state == ST_OWN) && i_xfer_req && !forced_release_in_n;
         o_resume_cycle <= (state == ST_OWN) && i_xfer_req && !forced_release_in_n && pending_retry;
         if (next_state == ST_BACKOFF) pending_retry <= 1'b1;
         else if (o_start_cycle) pending_retry <= 1'b0;
      end
   end

   // slave select response per bus mode
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_slave_selected <= 1'b0;
         o_cache_ack_out_n <= 1'b1;
         o_cache_ack_oe <= 1'b0;
         o_burst_inhibit_out_n <= 1'b1;
         o_burst_inhibit_oe <= 1'b0;
      end
      else
      begin
         o_slave_selected <= cs;
         o_cache_ack_out_n <= 1'b1;
         o_cache_ack_oe <= cs && is_mode_one(mode);
         o_burst_inhibit_out_n <= !(cs && !is_mode_one(mode));
         o_burst_inhibit_oe <= cs && !is_mode_one(mode);
      end
   end

   // script memory access on the leading edge of its select
   always_ff @(posedge i_clk)
   begin
      if (i_rst) rsel_d <= 1'b0;
      else rsel_d <= rsel;
   end

   assign ram_hit = rsel && !rsel_d && i_chip_test_ctrl_five[RAM_EN_BIT_A] &&
                    i_chip_test_ctrl_five[RAM_EN_BIT_B];
   assign ram.addr = addr[HOST_AW-1:2];
   assign ram.wdata = wdata;
   assign ram.we = ram_hit && wr;
   assign ram.rd = ram_hit && !wr;

   hba_script_ram #(
      .DEPTH(RAM_DEPTH)
   ) u_ram (
      .i_clk(i_clk),
      .ram(ram.mem)
   );

   // read data re-registered so the pins come from flip-flops
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_ram_rdata <= '0;
         o_ram_rvalid <= 1'b0;
      end
      else
      begin
         o_ram_rdata <= ram.rdata;
         o_ram_rvalid <= ram.rvalid;
      end
   end

   // interrupt pin follows the service request
   always_ff @(posedge i_clk)
   begin
      if (i_rst) o_irq_n <= 1'b1;
      else o_irq_n <= !i_service_req;
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_seek;
      state == ST_IDLE && i_xfer_req;
   endsequence
   sequence s_late_forced_release_in_n;
      state == ST_OWN && i_xfer_req && forced_release_in_n;
   endsequence
   sequence s_arb_forced_release_in_n;
      state == ST_REQ && bus_free && forced_release_in_n ##1 i_xfer_req;
   endsequence

   chk_request_low: assert property (s_seek |=> !o_host_bus_request_n)
      else $error("request not asserted when seeking bus");
   chk_grant_owns: assert property (state == ST_REQ && bus_free |=> o_bus_owner &&
      o_host_bus_request_n)
      else $error("grant did not give ownership");
   chk_taken_mode: assert property (o_mastership_taken_oe |-> o_bus_owner &&
      is_mode_one(mode))
      else $error("grant-ack driven outside mode one ownership");
   chk_busy_mode: assert property (o_mastership_wired_busy_oe |-> o_bus_owner &&
      !is_mode_one(mode))
      else $error("busy driven outside ownership");
   chk_forced_release_in_n_cycle_end: assert property (state == ST_CYCLE && i_cycle_done && forced_release_in_n |=>
      !o_bus_owner)
      else $error("bus kept after back-off at cycle end");
   chk_rearb_after: assert property (state == ST_BACKOFF && !forced_release_in_n && i_xfer_req |=>
      !o_host_bus_request_n)
      else $error("no new arbitration after back-off");
   chk_start_sample: assert property (o_start_cycle |-> !$past(forced_release_in_n))
      else $error("start cycle issued under back-off");
   chk_late_release: assert property (s_late_forced_release_in_n |-> ##[1:3] !o_bus_owner)
      else $error("late back-off release took too long");
   chk_arb_then_off: assert property (s_arb_forced_release_in_n |=> ##[0:4] !o_bus_owner)
      else $error("arbitration back-off not honoured");
   chk_slave_resp: assert property (cs && !is_mode_one(mode) |=> o_burst_inhibit_oe &&
      !o_burst_inhibit_out_n)
      else $error("burst inhibit not asserted on select");
   chk_ram_read: assert property (ram_hit && !wr |-> ##2 o_ram_rvalid)
      else $error("script memory read gave no data");
   chk_irq_follow: assert property (i_service_req |=> !o_irq_n)
      else $error("interrupt not asserted");
endmodule // hba_host_arbiter

/* test/hba_arb_partner.sv */
// far-side arbiter model: grants the host bus and resolves the shared wires
`timescale 1ns/100ps
module hba_arb_partner (
   input wire logic i_clk,       // host bus clock
   input wire logic i_rst,       // reset, high
   input wire logic [3:0] i_lag, // grant delay in cycles
   input wire logic i_req_n,     // request from block
   input wire logic i_tk_oe,     // block drives grant-ack
   input wire logic i_tk_n,      // block grant-ack value
   input wire logic i_bz_oe,     // block drives busy
   input wire logic i_bz_n,      // block busy value
   output logic o_grant_n,       // grant to block
   output logic o_tk_wire_n,     // grant-ack wire level
   output logic o_bz_wire_n      // busy wire level
);
   logic [3:0] wait_cnt;
   // grant after the chosen lag, withdraw once the request is dropped
   always_ff @(posedge i_clk)
   begin
      if (i_rst || i_req_n)
      begin
         wait_cnt <= 4'h0;
         o_grant_n <= 1'b1;
      end
      else if (wait_cnt >= i_lag)
         o_grant_n <= 1'b0;
      else
         wait_cnt <= wait_cnt + 4'h1;
   end
   // pulled-up wires: only a driving owner pulls them low
   assign o_tk_wire_n = i_tk_oe ? i_tk_n : 1'b1;
   assign o_bz_wire_n = i_bz_oe ? i_bz_n : 1'b1;
endmodule // hba_arb_partner

/* test/host_bus_arbitration_bench.sv */
// self-checking bench for the host bus arbitration block
`timescale 1ns/100ps
module host_bus_arbitration_bench;
   import hba_pkg::*;
   logic clk, rst, xfer, done, forced_release_in_n_n, cs_n, ram_n, wr, svc, seen_res;
   logic [1:0] mode;
   logic [7:0] ctrl;
   logic [HOST_AW-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [3:0] lag;
   logic grant_n, tk_n, tk_oe, tkw_n, bz_n, bz_oe, bzw_n, req_n, start, res, owner;
   logic ca_n, ca_oe, bi_n, bi_oe, slv, rvalid, irq_n;
   int fails, n_tests, n_start, n_rv;

   hba_host_arbiter u_dut (.i_clk(clk), .i_rst(rst), .i_bus_mode(mode),
      .i_host_grant_in_n(grant_n), .i_forced_release_in_n(forced_release_in_n_n),
      .i_mastership_taken_n(tkw_n), .o_mastership_taken_n(tk_n),
      .o_mastership_taken_oe(tk_oe), .i_mastership_wired_busy_n(bzw_n),
      .o_mastership_wired_busy_n(bz_n), .o_mastership_wired_busy_oe(bz_oe),
      .o_host_bus_request_n(req_n), .i_xfer_req(xfer), .i_cycle_done(done),
      .o_start_cycle(start), .o_resume_cycle(res), .o_bus_owner(owner),
      .i_chip_select_n(cs_n), .o_cache_ack_out_n(ca_n), .o_cache_ack_oe(ca_oe),
      .o_burst_inhibit_out_n(bi_n), .o_burst_inhibit_oe(bi_oe),
      .o_slave_selected(slv), .i_script_memory_select_n(ram_n),
      .i_chip_test_ctrl_five(ctrl), .i_host_addr(addr), .i_host_wdata(wdata),
      .i_host_write(wr), .o_ram_rdata(rdata), .o_ram_rvalid(rvalid),
      .i_service_req(svc), .o_irq_n(irq_n));
   hba_arb_partner u_far (.i_clk(clk), .i_rst(rst), .i_lag(lag), .i_req_n(req_n),
      .i_tk_oe(tk_oe), .i_tk_n(tk_n), .i_bz_oe(bz_oe), .i_bz_n(bz_n),
      .o_grant_n(grant_n), .o_tk_wire_n(tkw_n), .o_bz_wire_n(bzw_n));

   // clock and pulse counters
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      n_start += (start === 1'b1);
      n_rv += (rvalid === 1'b1);
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // bounded wait: k picks owner, request, start, read valid
   task automatic wait_ev(input int k, input logic v);
      logic [3:0] ev;
      int i;
      for (i = 0; i < 60; i++)
      begin
         ev = {rvalid, start, req_n, owner};
         if (ev[k] === v)
            break;
         cyc(1);
      end
      seen_res = res;
      if (i == 60)
      begin
         fails++;
         $display("mismatch wait %0d expected %b seen timeout", k, v);
         wrap_up();
      end
   endtask
   task automatic pulse_done();
      done = 1'b1;
      cyc(1);
      done = 1'b0;
   endtask
   // drop the transfer and see the bus handed back
   task automatic leave();
      xfer = 1'b0;
      pulse_done();
      wait_ev(0, 1'b0);
      check("oe released", {tk_oe, bz_oe}, 0);
   endtask

   task automatic test_arb(input logic [1:0] m);
      mode = m;
      lag = {2'h0, m};
      cyc(4);
      xfer = 1'b1;
      wait_ev(1, 1'b0);
      wait_ev(0, 1'b1);
      check("request_n owned", req_n, 1);
      check("grant ack oe", tk_oe, m == MODE_ONE);
      check("grant ack wire", tkw_n, m != MODE_ONE);
      check("busy wire", bzw_n, m == MODE_ONE);
      wait_ev(2, 1'b1);
      check("fresh start", seen_res, 0);
      cyc(2);
      check("owner in cycle", owner, 1);
      pulse_done();
      wait_ev(2, 1'b1);
      leave();
      $display("test arbitration mode %0d done", m);
   endtask

   task automatic test_backoff();
      xfer = 1'b1;
      wait_ev(2, 1'b1);
      forced_release_in_n_n = 1'b0;
      cyc(3);
      pulse_done();
      wait_ev(0, 1'b0);
      cyc(6);
      check("off bus in back-off", {owner, req_n}, 1);
      forced_release_in_n_n = 1'b1;
      wait_ev(1, 1'b0);
      wait_ev(2, 1'b1);
      check("resume", seen_res, 1);
      leave();
      $display("test back-off in cycle done");
   endtask

   task automatic test_forced_release_in_n_arb();
      int s0;
      s0 = n_start;
      forced_release_in_n_n = 1'b0;
      xfer = 1'b1;
      wait_ev(0, 1'b1);
      wait_ev(0, 1'b0);
      check("start became release", n_start, s0);
      forced_release_in_n_n = 1'b1;
      wait_ev(2, 1'b1);
      check("resume after arb", seen_res, 1);
      leave();
      $display("test back-off in arbitration done");
   endtask

   task automatic test_slave();
      for (int m = 0; m < 4; m++)
      begin
         mode = m[1:0];
         cyc(4);
         cs_n = 1'b0;
         cyc(4);
         check("slave seen", slv, 1);
         check("cache ack", {ca_oe, ca_n}, (m == 0) ? 3 : 1);
         check("burst inh", {bi_oe, bi_n}, (m != 0) ? 2 : 1);
         cs_n = 1'b1;
         cyc(4);
         check("slave off", {ca_oe, bi_oe, slv}, 0);
      end
      $display("test slave select done");
   endtask

   task automatic test_ram();
      int r0;
      ctrl = 8'h06;
      addr = 12'hFFC;
      wdata = 32'hA5C30F96;
      wr = 1'b1;
      ram_n = 1'b0;
      cyc(4);
      ram_n = 1'b1;
      cyc(4);
      wr = 1'b0;
      ram_n = 1'b0;
      wait_ev(3, 1'b1);
      check("ram read", rdata, 32'hA5C30F96);
      ram_n = 1'b1;
      cyc(4);
      ctrl = 8'h02;
      r0 = n_rv;
      ram_n = 1'b0;
      cyc(8);
      ram_n = 1'b1;
      check("window closed", n_rv, r0);
      $display("test script memory done");
   endtask

   task automatic test_irq();
      svc = 1'b1;
      cyc(1);
      check("irq asserted", irq_n, 0);
      svc = 1'b0;
      cyc(1);
      check("irq released", irq_n, 1);
      $display("test interrupt done");
   endtask

   initial
   begin
      {fails, n_tests, n_start, n_rv} = 0;
      {rst, forced_release_in_n_n, cs_n, ram_n} = 4'hF;
      {xfer, done, wr, svc, mode, ctrl, addr, wdata, lag} = 0;
      cyc(3);
      check("request_n", req_n, 1);
      check("owner irq_n", {owner, irq_n}, 1);
      check("oe", {tk_oe, bz_oe, ca_oe, bi_oe}, 0);
      rst = 1'b0;
      cyc(2);
      check("quiet after reset", {slv, ca_oe, start, rvalid}, 0);
      $display("test reset done");
      for (int m = 0; m < 4; m++)
         test_arb(m[1:0]);
      test_backoff();
      test_forced_release_in_n_arb();
      test_slave();
      test_ram();
      test_irq();
      wrap_up();
   end
endmodule // host_bus_arbitration_bench
